// file: rtl/rac_pkg.sv
// Purpose: Shared constants and types for the alarm control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register offsets are byte addresses
package rac_pkg;
   localparam logic [11:0] RAC_ADDR_CTRL = 12'h000;
   localparam logic [11:0] RAC_ADDR_DATE = 12'h004;
   localparam logic [11:0] RAC_ADDR_TIME = 12'h008;
   localparam logic [11:0] RAC_ADDR_STAT = 12'h00C;
   localparam logic [11:0] RAC_ADDR_MASK = 12'h010;
   localparam int RAC_B_EN = 15;
   localparam int RAC_B_WRAP = 14;
   localparam int RAC_B_PIV = 13;
   localparam int RAC_B_SYNC = 12;
   localparam int RAC_B_IVH = 11;
   localparam int RAC_B_IVL = 8;
   localparam int RAC_B_RCH = 7;
   localparam logic [15:0] RAC_CTRL_RST = 16'h0000;
   localparam logic [23:0] RAC_DATE_RST = 24'h000000;
   localparam logic [23:0] RAC_TIME_RST = 24'h000000;
   localparam logic [7:0] RAC_CNT_ZERO = 8'h00;
   localparam logic [7:0] RAC_CNT_MAX = 8'hFF;
   localparam logic [23:0] RAC_DATE_WMASK = 24'h1F3F07;
   localparam logic [3:0] RAC_MONTH_TENS_MAX = 4'h1;
   localparam logic [7:0] RAC_FEB = 8'h02;
   localparam logic [7:0] RAC_DAY29 = 8'h29;
   localparam logic [1:0] RAC_LEAP_PHASE = 2'h0;
   localparam int RAC_SYNC_GUARD = 32;
   localparam logic [1:0] RAC_IRQ_ALARM = 2'h1;
   localparam logic [1:0] RAC_IRQ_SYNC = 2'h2;
   localparam logic [31:0] RAC_ZERO32 = 32'h00000000;
   typedef enum logic [3:0] {
      RAC_IV_HALF = 4'h0, RAC_IV_SEC = 4'h1, RAC_IV_SEC10 = 4'h2, RAC_IV_MIN = 4'h3,
      RAC_IV_MIN10 = 4'h4, RAC_IV_HOUR = 4'h5, RAC_IV_DAY = 4'h6, RAC_IV_WEEK = 4'h7,
      RAC_IV_MONTH = 4'h8, RAC_IV_YEAR = 4'h9
   } rac_interval_t;
   // Date fields: month tens/ones, day tens/ones, weekday
   typedef struct packed {
      logic [3:0] month_tens_digit;
      logic [3:0] month_ones;
      logic [3:0] day_tens;
      logic [3:0] day_ones;
      logic [3:0] unused;
      logic [3:0] weekday;
   } rac_date_t;
   // Time fields: hour, minute, second BCD pairs
   typedef struct packed {
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } rac_time_t;
endpackage

// file: rtl/rac_match_if.sv
// Purpose: Carries alarm comparison inputs and the match result
// Assumes: Single clock domain
// Notes: Used between the top and the comparator
`timescale 1ns/100ps
interface rac_match_if;
   import rac_pkg::*;
   rac_date_t now_date;
   rac_time_t now_time;
   rac_date_t alm_date;
   rac_time_t alm_time;
   logic [3:0] interval_select;
   logic [1:0] year_phase;
   logic half_tick;
   logic sec_tick;
   logic match;
   modport ctrl (output now_date, now_time, alm_date, alm_time, interval_select, year_phase,
      half_tick, sec_tick, input match);
   modport cmp (input now_date, now_time, alm_date, alm_time, interval_select, year_phase,
      half_tick, sec_tick, output match);
endinterface

// file: rtl/rac_match.sv
// Purpose: Decides when the running time hits the alarm value
// Assumes: Ticks are one-cycle pulses at each half-second boundary
// Notes: Reserved interval codes never match
`timescale 1ns/100ps
module rac_match (
   rac_match_if.cmp m
);
   import rac_pkg::*;
   logic sec_eq, min_eq, hour_eq, wday_eq, day_eq, mon_eq, leap_ok;
   always_comb begin
      sec_eq = (m.now_time.second == m.alm_time.second);
      min_eq = (m.now_time.minute == m.alm_time.minute);
      hour_eq = (m.now_time.hour == m.alm_time.hour);
      wday_eq = (m.now_date.weekday == m.alm_date.weekday);
      day_eq = ({m.now_date.day_tens, m.now_date.day_ones} ==
         {m.alm_date.day_tens, m.alm_date.day_ones});
      mon_eq = ({m.now_date.month_tens_digit, m.now_date.month_ones} ==
         {m.alm_date.month_tens_digit, m.alm_date.month_ones});
      // Feb 29 only exists in the leap phase of the four-year cycle
      leap_ok = !(({m.alm_date.month_tens_digit, m.alm_date.month_ones} == RAC_FEB) &&
         ({m.alm_date.day_tens, m.alm_date.day_ones} == RAC_DAY29)) ||
         (m.year_phase == RAC_LEAP_PHASE);
      m.match = 1'b0;
      unique case (m.interval_select)
         RAC_IV_HALF: m.match = m.half_tick;
         RAC_IV_SEC: m.match = m.sec_tick;
         RAC_IV_SEC10: m.match = m.sec_tick && (m.now_time.second[3:0] == m.alm_time.second[3:0]);
         RAC_IV_MIN: m.match = m.sec_tick && sec_eq;
         RAC_IV_MIN10: m.match = m.sec_tick && sec_eq &&
            (m.now_time.minute[3:0] == m.alm_time.minute[3:0]);
         RAC_IV_HOUR: m.match = m.sec_tick && sec_eq && min_eq;
         RAC_IV_DAY: m.match = m.sec_tick && sec_eq && min_eq && hour_eq;
         RAC_IV_WEEK: m.match = m.sec_tick && sec_eq && min_eq && hour_eq && wday_eq;
         RAC_IV_MONTH: m.match = m.sec_tick && sec_eq && min_eq && hour_eq && day_eq;
         RAC_IV_YEAR: m.match = m.sec_tick && sec_eq && min_eq && hour_eq && day_eq &&
            mon_eq && leap_ok;
         default: m.match = 1'b0;
      endcase
   end
endmodule

// file: rtl/rac_top.sv
// What this block does
// - Alarm events happen only while the alarm enable bit is set.
// - With repeat-wrap set, repeat count rolls 0x00 to 0xFF, alarms continue.
// - With repeat-wrap clear, repeat count stops at zero.
// - With alarm disabled, pulse initial value is writable and sets pulse level.
// - With alarm enabled, pulse value ignores writes and reads the live pulse.
// - Rollover-pending flag is clear only when over 32 ticks from rollover.
// - Interval field decodes half-second up to year; higher codes reserved.
// - Yearly alarm on February 29 fires once every four years.
// - Alarm event at count zero without repeat-wrap clears the enable bit.
// - Control register returns to reset state only on power-on reset.
// - Bit layout 15 enable,14 wrap,13 pulse,12 flag,11-8 interval,7-0 count.
// - Alarm date holds BCD month, day, weekday; month tens is zero or one.
// Purpose: Alarm control register, matcher and alarm pulse of a calendar clock
// Assumes: Timebase ticks and current time come from the rest of the clock unit
// Notes: sys_rst_i is the power-on reset; other resets are not wired in
`timescale 1ns/100ps
module rac_top (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic unit_on_i,
   input wire logic [14:0] prescaler_i,
   input wire logic half_tick_i,
   input wire logic sec_tick_i,
   input wire logic [1:0] year_phase_i,
   input wire rac_pkg::rac_date_t now_date_i,
   input wire rac_pkg::rac_time_t now_time_i,
   output logic alarm_pulse_o,
   output logic alarm_event_o,
   output logic irq_o
);
   import rac_pkg::*;
   logic alarm_enable_bit_reg;
   logic wrap_reg;
   logic pulse_reg;
   logic rollover_pending_flag_reg;
   logic [3:0] interval_select_reg;
   logic [7:0] repeat_count_reg;
   rac_date_t alarm_date_value_reg;
   rac_time_t alarm_time_reg;
   logic [1:0] stat_reg;
   logic [1:0] mask_reg;
   logic [1:0] stat_next;
   logic access, wr, rd, hit_ctrl, hit_date, hit_time, hit_stat, hit_mask, mapped;
   logic fire, sync_set, sync_rise;
   logic [31:0] rdata;
   logic [15:0] ctrl_view;
   rac_match_if mif ();
   assign mif.now_date = now_date_i;
   assign mif.now_time = now_time_i;
   assign mif.alm_date = alarm_date_value_reg;
   assign mif.alm_time = alarm_time_reg;
   assign mif.interval_select = interval_select_reg;
   assign mif.year_phase = year_phase_i;
   assign mif.half_tick = half_tick_i;
   assign mif.sec_tick = sec_tick_i;
   rac_match u_match (
      .m(mif)
   );
   always_comb begin
      access = psel_i && penable_i;
      wr = access && pwrite_i;
      rd = access && !pwrite_i;
      hit_ctrl = (paddr_i == RAC_ADDR_CTRL);
      hit_date = (paddr_i == RAC_ADDR_DATE);
      hit_time = (paddr_i == RAC_ADDR_TIME);
      hit_stat = (paddr_i == RAC_ADDR_STAT);
      hit_mask = (paddr_i == RAC_ADDR_MASK);
      mapped = hit_ctrl || hit_date || hit_time || hit_stat || hit_mask;
      fire = mif.match && alarm_enable_bit_reg;
      // Prescaler counts down to zero at the half-second rollover
      sync_set = (prescaler_i <= 15'(RAC_SYNC_GUARD));
      sync_rise = sync_set && !rollover_pending_flag_reg;
   end
   always_comb begin
      ctrl_view = {alarm_enable_bit_reg, wrap_reg, pulse_reg, rollover_pending_flag_reg,
         interval_select_reg, repeat_count_reg};
      rdata = RAC_ZERO32;
      if (hit_ctrl) begin
         rdata = {16'h0000, ctrl_view};
      end else if (hit_date) begin
         rdata = {8'h00, alarm_date_value_reg};
      end else if (hit_time) begin
         rdata = {8'h00, alarm_time_reg};
      end else if (hit_stat) begin
         rdata = {30'h0, stat_reg};
      end else if (hit_mask) begin
         rdata = {30'h0, mask_reg};
      end
   end
   // Zero-wait APB slave: pready is high in every access phase
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= RAC_ZERO32;
      end else begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && !mapped;
         if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rdata;
         end
      end
   end
   // Control word, reset only by power-on reset
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         alarm_enable_bit_reg <= RAC_CTRL_RST[RAC_B_EN];
         wrap_reg <= RAC_CTRL_RST[RAC_B_WRAP];
         interval_select_reg <= RAC_CTRL_RST[RAC_B_IVH:RAC_B_IVL];
         repeat_count_reg <= RAC_CTRL_RST[RAC_B_RCH:0];
      end else begin
         if (wr && pready_o && hit_ctrl) begin
            alarm_enable_bit_reg <= pwdata_i[RAC_B_EN];
            wrap_reg <= pwdata_i[RAC_B_WRAP];
            interval_select_reg <= pwdata_i[RAC_B_IVH:RAC_B_IVL];
            repeat_count_reg <= pwdata_i[RAC_B_RCH:0];
         end
         // Hardware update wins over a write landing in the same cycle
         if (fire) begin
            if (repeat_count_reg != RAC_CNT_ZERO) begin
               repeat_count_reg <= repeat_count_reg - 8'h01;
            end else if (wrap_reg) begin
               repeat_count_reg <= RAC_CNT_MAX;
            end else begin
               repeat_count_reg <= RAC_CNT_ZERO;
               alarm_enable_bit_reg <= 1'b0;
            end
         end
      end
   end
   // Alarm pulse level doubles as the pulse initial value bit
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pulse_reg <= RAC_CTRL_RST[RAC_B_PIV];
      end else if (fire) begin
         pulse_reg <= !pulse_reg;
      end else if (wr && pready_o && hit_ctrl && !alarm_enable_bit_reg) begin
         pulse_reg <= pwdata_i[RAC_B_PIV];
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rollover_pending_flag_reg <= 1'b0;
      end else begin
         rollover_pending_flag_reg <= sync_set;
      end
   end
   // Alarm compare values; month tens digit trimmed to one bit
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         alarm_date_value_reg <= RAC_DATE_RST;
         alarm_time_reg <= RAC_TIME_RST;
      end else begin
         if (wr && pready_o && hit_date) begin
            alarm_date_value_reg <= pwdata_i[23:0] & RAC_DATE_WMASK;
         end
         if (wr && pready_o && hit_time) begin
            alarm_time_reg <= pwdata_i[23:0];
         end
      end
   end
   always_comb begin
      stat_next = stat_reg;
      if (rd && pready_o && hit_stat) begin
         stat_next = 2'h0;
      end
      // Set wins over a clearing read
      if (fire) begin
         stat_next = stat_next | RAC_IRQ_ALARM;
      end
      if (sync_rise) begin
         stat_next = stat_next | RAC_IRQ_SYNC;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         stat_reg <= 2'h0;
         mask_reg <= 2'h0;
      end else begin
         stat_reg <= stat_next;
         if (wr && pready_o && hit_mask) begin
            mask_reg <= pwdata_i[1:0];
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         irq_o <= 1'b0;
         alarm_event_o <= 1'b0;
         alarm_pulse_o <= 1'b0;
      end else begin
         irq_o <= |(stat_next & mask_reg);
         alarm_event_o <= fire;
         alarm_pulse_o <= fire ? !pulse_reg : pulse_reg;
      end
   end
   // Unit-on input is only a software hazard qualifier; no hardware gating
   logic unused_on;
   assign unused_on = unit_on_i;

   // Steps of one counted alarm event; the count and the pulse move together
   sequence s_fire_counting;
      fire && repeat_count_reg != RAC_CNT_ZERO;
   endsequence
   sequence s_counted_down;
      repeat_count_reg == $past(repeat_count_reg) - 8'h01 && pulse_reg != $past(pulse_reg);
   endsequence
   // Setup phase of a bus transfer
   sequence s_setup_phase;
      psel_i && !penable_i;
   endsequence

   property p_no_event_disabled;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !alarm_enable_bit_reg |=> !alarm_event_o;
   endproperty
   a_no_event_disabled: assert property (p_no_event_disabled)
      else $error("alarm event while disabled");

   property p_wrap;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      fire && wrap_reg && repeat_count_reg == RAC_CNT_ZERO
      |=> repeat_count_reg == RAC_CNT_MAX;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("count did not wrap");

   property p_stop;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      fire && !wrap_reg && repeat_count_reg == RAC_CNT_ZERO
      |=> repeat_count_reg == RAC_CNT_ZERO && !alarm_enable_bit_reg;
   endproperty
   a_stop: assert property (p_stop)
      else $error("count or enable wrong at zero");

   property p_piv_write;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      wr && pready_o && hit_ctrl && !alarm_enable_bit_reg && !fire
      |=> pulse_reg == $past(pwdata_i[RAC_B_PIV]);
   endproperty
   a_piv_write: assert property (p_piv_write)
      else $error("pulse value not written");

   property p_piv_hold;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      alarm_enable_bit_reg && !fire |=> pulse_reg == $past(pulse_reg);
   endproperty
   a_piv_hold: assert property (p_piv_hold)
      else $error("pulse changed while enabled");

   property p_sync_far;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      prescaler_i > 15'(RAC_SYNC_GUARD) |=> !rollover_pending_flag_reg;
   endproperty
   a_sync_far: assert property (p_sync_far)
      else $error("flag set far from rollover");

   property p_sync_near;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      prescaler_i <= 15'(RAC_SYNC_GUARD) |=> rollover_pending_flag_reg;
   endproperty
   a_sync_near: assert property (p_sync_near)
      else $error("flag clear near rollover");

   property p_dec;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_fire_counting |=> s_counted_down;
   endproperty
   a_dec: assert property (p_dec)
      else $error("count or pulse wrong on event");

   property p_count_hold;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !fire && !(wr && pready_o && hit_ctrl) |=> $stable(repeat_count_reg);
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("count moved without event or write");

   property p_reserved;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      interval_select_reg > RAC_IV_YEAR |-> !mif.match;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved interval matched");

   property p_month;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      alarm_date_value_reg.month_tens_digit <= RAC_MONTH_TENS_MAX;
   endproperty
   a_month: assert property (p_month)
      else $error("month tens out of range");

   property p_event_flag;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      fire |=> alarm_event_o && stat_reg[0];
   endproperty
   a_event_flag: assert property (p_event_flag)
      else $error("event not flagged");

   property p_irq_masked;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      mask_reg == 2'h0 |=> !irq_o;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("interrupt with all sources masked");

   // Bus answer: one access phase, answered in the cycle after setup
   property p_pready_setup;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_setup_phase |=> pready_o;
   endproperty
   a_pready_setup: assert property (p_pready_setup)
      else $error("no ready after setup");

   property p_pready_single;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      pready_o |=> !pready_o;
   endproperty
   a_pready_single: assert property (p_pready_single)
      else $error("ready held two cycles");

   property p_slverr;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      psel_i && !penable_i && !mapped |=> pslverr_o && pready_o;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("unmapped access not refused");

   property p_ctrl_upper;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      pready_o && !pwrite_i && hit_ctrl |-> prdata_o[31:16] == 16'h0000;
   endproperty
   a_ctrl_upper: assert property (p_ctrl_upper)
      else $error("control upper bits not zero");
endmodule

// file: tb/rac_top_test.sv
// Purpose: Self-checking bench for the alarm control block
// Assumes: Mask bit set lets its status bit reach irq; alarm value fields left at reset
// Notes: With the alarm value at reset, a non-reserved code fires when the time fields equal it
`timescale 1ns/100ps
module rac_top_test;
   import rac_pkg::*;
   logic core_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, unit_on_i;
   logic half_tick_i, sec_tick_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, q, xs_state;
   logic pready_o, pslverr_o, alarm_pulse_o, alarm_event_o, irq_o, e;
   logic [14:0] prescaler_i;
   logic [1:0] year_phase_i;
   rac_date_t now_date_i;
   rac_time_t now_time_i;
   int errors, checks_done, ev_seen, exp_ev, m_en, m_wrap, m_pulse, m_iv, m_cnt, m_st, c;
   rac_top rac_top_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .unit_on_i(unit_on_i),
      .prescaler_i(prescaler_i), .half_tick_i(half_tick_i), .sec_tick_i(sec_tick_i),
      .year_phase_i(year_phase_i), .now_date_i(now_date_i), .now_time_i(now_time_i),
      .alarm_pulse_o(alarm_pulse_o), .alarm_event_o(alarm_event_o), .irq_o(irq_o));
   always #25 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      if (alarm_event_o === 1'b1) ev_seen <= ev_seen + 1;
   end
   function automatic logic [31:0] xs();
      xs_state = xs_state ^ (xs_state << 13);
      xs_state = xs_state ^ (xs_state >> 17);
      xs_state = xs_state ^ (xs_state << 5);
      return xs_state;
   endfunction
   task automatic end_of_test();
      if (errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge core_clk_i);
      end while (pready_o !== 1'b1);
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr_ctrl(input logic [31:0] d);
      apb(1'b1, RAC_ADDR_CTRL, d);
      if (m_en == 0) m_pulse = d[RAC_B_PIV];
      m_en = d[RAC_B_EN];
      m_wrap = d[RAC_B_WRAP];
      m_iv = d[RAC_B_IVH:RAC_B_IVL];
      m_cnt = d[RAC_B_RCH:0];
   endtask
   task automatic chk_ctrl();
      logic [31:0] x, p;
      apb(1'b0, RAC_ADDR_CTRL, 32'h00000000);
      p = ~q;
      while (q[RAC_B_SYNC] === 1'b1 && q !== p) begin
         p = q;
         apb(1'b0, RAC_ADDR_CTRL, 32'h00000000);
      end
      x = {16'h0000, m_en[0], m_wrap[0], m_pulse[0], (int'(prescaler_i) <= RAC_SYNC_GUARD),
         m_iv[3:0], m_cnt[7:0]};
      cmp("ctrl", x, q);
      cmp("pulse", {31'h0, m_pulse[0]}, {31'h0, alarm_pulse_o});
      cmp("events", exp_ev, ev_seen);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge core_clk_i);
         half_tick_i <= 1'b1;
         sec_tick_i <= 1'b1;
         @(posedge core_clk_i);
         half_tick_i <= 1'b0;
         sec_tick_i <= 1'b0;
         repeat (4) @(posedge core_clk_i);
         if (m_en != 0 && (m_iv < 2 || (m_iv < 10 && now_time_i == RAC_TIME_RST &&
               now_date_i == RAC_DATE_RST))) begin
            exp_ev++;
            m_st = 1;
            m_pulse = 1 - m_pulse;
            if (m_cnt == 0 && m_wrap == 0) m_en = 0;
            else m_cnt = (m_cnt + 255) % 256;
         end
      end
   endtask
   initial begin
      core_clk_i = 0;
      sys_rst_i = 1;
      {psel_i, penable_i, pwrite_i, half_tick_i, sec_tick_i} = '0;
      unit_on_i = 1;
      paddr_i = '0;
      pwdata_i = '0;
      prescaler_i = 15'h03E8;
      year_phase_i = 2'h0;
      now_date_i = RAC_DATE_RST;
      now_time_i = RAC_TIME_RST;
      xs_state = 32'hE1E0;
      {errors, checks_done, ev_seen, exp_ev, m_en, m_wrap, m_pulse, m_iv, m_cnt, m_st} = '0;
      repeat (12) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      chk_ctrl();
      apb(1'b0, 12'h020, 32'h00000000);
      cmp("unmapped", 32'h00000001, {q[30:0], e});
      for (c = 0; c < 14; c++) wr_ctrl(c < 10 ? c << 8 : xs() & 32'hFFFF7FFF);
      chk_ctrl();
      // Flag must follow the live prescaler distance, not a latched copy
      @(posedge core_clk_i) prescaler_i <= 15'h0020;
      chk_ctrl();
      @(posedge core_clk_i) prescaler_i <= 15'h0021;
      chk_ctrl();
      apb(1'b0, RAC_ADDR_STAT, 32'h00000000);
      for (c = 10; c < 16; c++) begin
         wr_ctrl(32'h8005 | (c << 8));
         tick(1);
      end
      wr_ctrl(32'h00000000);
      tick(1);
      chk_ctrl();
      wr_ctrl(32'h00008002);
      tick(1);
      cmp("irq", 32'h0, {31'h0, irq_o});
      apb(1'b1, RAC_ADDR_MASK, 32'h00000001);
      repeat (2) @(posedge core_clk_i);
      cmp("irq", 32'h1, {31'h0, irq_o});
      apb(1'b0, RAC_ADDR_STAT, 32'h00000000);
      cmp("status", m_st, q & 32'h1);
      m_st = 0;
      repeat (2) @(posedge core_clk_i);
      cmp("irq", 32'h0, {31'h0, irq_o});
      apb(1'b1, RAC_ADDR_MASK, 32'h00000000);
      tick(3);
      chk_ctrl();
      wr_ctrl(32'h0000C001 | ((1 - m_pulse) << RAC_B_PIV));
      chk_ctrl();
      tick(3);
      chk_ctrl();
      // Low codes see one second of difference, high codes an exact match
      for (c = 1; c < 10; c++) begin
         now_time_i.second <= (c > 5) ? 8'h00 : 8'h01;
         wr_ctrl(32'h0000C000 | (c << 8));
         tick(1);
      end
      chk_ctrl();
      wr_ctrl(32'h00002000);
      chk_ctrl();
      end_of_test();
   end
   initial begin
      #1000000;
      errors++;
      end_of_test();
   end
endmodule
